// >>> core/flash_status_reg_one_logic.sv
// volatile status register one with command gating for a serial flash
// What this block does
// - bit 7 mirrors the persistent write lock
// - program failure or protected target sets bit6
// - erase failure or protected sector sets bit5
// - whole array erase never raises erase error
// - error flags read-only, cleared by clear-status
// - protect source selects persistent or volatile bits
// - any active protect bit blocks region writes
// - whole erase only with all protect bits zero
// - modifying commands need write enable latch set
// - enable sets latch, disable clears it
// - successful operation clears the latch
// - any reset clears the write enable latch
// - register writes with the volatile protect source leave latch and busy alone; persistent writes set busy
// - busy flag high during any internal operation
// - busy accepts only status, reads, suspends, clears, soft reset
// - suspends accepted only during matching operation
// - error keeps busy high until clear-status
// - reset values loaded from persistent default bits
// - lock with write protect low blocks writes
// - exact opcodes for enable, disable, clear
`timescale 1ns/1ns
`default_nettype none
module flash_status_reg_one_logic (
  input wire logic clock,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic write_protect_n,
  input wire logic soft_reset,
  input wire logic [7:0] status_one_nonvolatile,
  input wire logic protect_source_select,
  input wire logic region_protected,
  input wire logic otp_locked_target,
  input wire logic op_done,
  input wire logic op_fail,
  output logic [7:0] status_one_volatile,
  output logic [7:0] nv_write_data,
  output logic nv_write_strobe,
  output logic op_start,
  output logic [2:0] op_kind,
  output logic [2:0] active_protect,
  output logic erase_suspend_req,
  output logic program_suspend_req
);
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HOLD} run_state_t;

  typedef struct packed {
    logic [1:0] wp_sync;
    logic [1:0] srst_sync;
    logic loaded;
    logic lock_copy;
    logic perr;
    logic eerr;
    logic [2:0] bp_vol;
    logic write_enable_latch;
    logic busy;
    run_state_t run;
    status_one_pkg::op_kind_t kind;
    logic [7:0] nv_data;
    logic nv_strobe;
    logic op_start;
    logic ers_req;
    logic pgm_req;
    logic [7:0] status_out;
    logic [2:0] active_bp;
  } state_t;

  state_t cur_ff, nxt_cur;
  logic frame_end;
  logic [7:0] opcode;
  logic [23:0] address;
  logic [7:0] data;
  logic data_valid;
  logic [2:0] bp_used;
  logic reg_locked;
  logic targets_reg_one;
  logic allowed_busy;
  logic is_clear;

  spi_cmd_shifter u_shifter (
    .clock(clock),
    .rst(rst),
    .sck(sck),
    .cs_n(cs_n),
    .mosi(mosi),
    .frame_end(frame_end),
    .opcode(opcode),
    .address(address),
    .data(data),
    .data_valid(data_valid),
    .count()
  );

  // commands that a busy device still takes
  function automatic logic busy_ok(input logic [7:0] op);
    busy_ok = (op == status_one_pkg::OP_READ_STATUS_ONE) ||
              (op == status_one_pkg::OP_READ_STATUS_TWO) ||
              (op == status_one_pkg::OP_ANY_REG_READ) ||
              (op == status_one_pkg::OP_ERASE_SUSPEND) ||
              (op == status_one_pkg::OP_PROGRAM_SUSPEND) ||
              (op == status_one_pkg::OP_CLEAR_STATUS) ||
              (op == status_one_pkg::OP_CLEAR_STATUS_ALT) ||
              (op == status_one_pkg::OP_SOFT_RESET);
  endfunction

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.wp_sync = {cur_ff.wp_sync[0], write_protect_n};
    nxt_cur.srst_sync = {cur_ff.srst_sync[0], soft_reset};
    nxt_cur.nv_strobe = 1'b0;
    nxt_cur.op_start = 1'b0;
    nxt_cur.ers_req = 1'b0;
    nxt_cur.pgm_req = 1'b0;
    nxt_cur.lock_copy = status_one_nonvolatile[status_one_pkg::BIT_LOCK];
    bp_used = protect_source_select ? cur_ff.bp_vol
                                    : status_one_nonvolatile[status_one_pkg::BIT_BP_HI:status_one_pkg::BIT_BP_LO];
    reg_locked = status_one_nonvolatile[status_one_pkg::BIT_LOCK] & ~cur_ff.wp_sync[1];
    targets_reg_one = (opcode == status_one_pkg::OP_STATUS_CONFIG_WRITE) ||
                      ((opcode == status_one_pkg::OP_ANY_REG_WRITE) &&
                       ((address == status_one_pkg::ADDR_STATUS_ONE_NV) ||
                        (address == status_one_pkg::ADDR_STATUS_ONE_V) ||
                        (address == status_one_pkg::ADDR_CONFIG_ONE_NV) ||
                        (address == status_one_pkg::ADDR_CONFIG_ONE_V)));
    allowed_busy = busy_ok(opcode);
    is_clear = (opcode == status_one_pkg::OP_CLEAR_STATUS) ||
               (opcode == status_one_pkg::OP_CLEAR_STATUS_ALT);

    // reset values from persistent defaults, taken after release
    if (!cur_ff.loaded || cur_ff.srst_sync[1]) begin
      nxt_cur.loaded = 1'b1;
      nxt_cur.perr = status_one_nonvolatile[status_one_pkg::BIT_PERR];
      nxt_cur.eerr = status_one_nonvolatile[status_one_pkg::BIT_EERR];
      nxt_cur.write_enable_latch = status_one_nonvolatile[status_one_pkg::BIT_WEL] & 1'b0;
      nxt_cur.busy = status_one_nonvolatile[status_one_pkg::BIT_BUSY];
      nxt_cur.bp_vol = status_one_nonvolatile[status_one_pkg::BIT_BP_HI:status_one_pkg::BIT_BP_LO];
      nxt_cur.run = ST_IDLE;
    end else begin
      // internal operation tracking
      case (cur_ff.run)
        ST_IDLE: begin
        end
        ST_RUN: begin
          if (op_done) begin
            if (op_fail) begin
              if (cur_ff.kind == status_one_pkg::OPK_ERASE) begin
                nxt_cur.eerr = 1'b1;
              end else if (cur_ff.kind == status_one_pkg::OPK_PROGRAM) begin
                nxt_cur.perr = 1'b1;
              end
              nxt_cur.run = ST_HOLD;
            end else begin
              nxt_cur.busy = 1'b0;
              nxt_cur.write_enable_latch = 1'b0;
              nxt_cur.run = ST_IDLE;
            end
          end
        end
        ST_HOLD: begin
          nxt_cur.busy = 1'b1;
        end
        default: begin
          nxt_cur.run = ST_IDLE;
        end
      endcase

      // command decode at end of frame
      if (frame_end) begin
        if (cur_ff.busy && !allowed_busy) begin
          // discarded while busy
        end else if (is_clear) begin
          // a failure reported in the same cycle wins over the clear
          if (!(op_done && op_fail && (cur_ff.run == ST_RUN))) begin
            nxt_cur.perr = 1'b0;
            nxt_cur.eerr = 1'b0;
            if (cur_ff.run == ST_HOLD) begin
              nxt_cur.busy = 1'b0;
              nxt_cur.run = ST_IDLE;
            end
          end
        end else if (opcode == status_one_pkg::OP_WRITE_ENABLE) begin
          nxt_cur.write_enable_latch = 1'b1;
        end else if (opcode == status_one_pkg::OP_WRITE_DISABLE) begin
          nxt_cur.write_enable_latch = 1'b0;
        end else if (opcode == status_one_pkg::OP_ERASE_SUSPEND) begin
          nxt_cur.ers_req = (cur_ff.run == ST_RUN) && (cur_ff.kind == status_one_pkg::OPK_ERASE);
        end else if (opcode == status_one_pkg::OP_PROGRAM_SUSPEND) begin
          nxt_cur.pgm_req = (cur_ff.run == ST_RUN) && (cur_ff.kind == status_one_pkg::OPK_PROGRAM);
        end else if (!cur_ff.write_enable_latch) begin
          // modifying commands ignored without the latch
        end else if (targets_reg_one && data_valid) begin
          if (!reg_locked) begin
            // latch and busy untouched by the data byte
            nxt_cur.bp_vol = data[status_one_pkg::BIT_BP_HI:status_one_pkg::BIT_BP_LO];
            if (!protect_source_select) begin
              nxt_cur.nv_data = data;
              nxt_cur.nv_strobe = 1'b1;
              nxt_cur.kind = status_one_pkg::OPK_REG_WRITE;
              nxt_cur.busy = 1'b1;
              nxt_cur.run = ST_RUN;
              nxt_cur.op_start = 1'b1;
            end
          end
        end else if (opcode == status_one_pkg::OP_PAGE_PROGRAM) begin
          if (region_protected && (bp_used != status_one_pkg::BP_ZERO) || otp_locked_target) begin
            nxt_cur.perr = 1'b1;
            nxt_cur.busy = 1'b1;
            nxt_cur.run = ST_HOLD;
          end else begin
            nxt_cur.kind = status_one_pkg::OPK_PROGRAM;
            nxt_cur.busy = 1'b1;
            nxt_cur.run = ST_RUN;
            nxt_cur.op_start = 1'b1;
          end
        end else if (opcode == status_one_pkg::OP_SECTOR_ERASE) begin
          if (region_protected && (bp_used != status_one_pkg::BP_ZERO)) begin
            nxt_cur.eerr = 1'b1;
            nxt_cur.busy = 1'b1;
            nxt_cur.run = ST_HOLD;
          end else begin
            nxt_cur.kind = status_one_pkg::OPK_ERASE;
            nxt_cur.busy = 1'b1;
            nxt_cur.run = ST_RUN;
            nxt_cur.op_start = 1'b1;
          end
        end else if (opcode == status_one_pkg::OP_WHOLE_ARRAY_ERASE) begin
          if (bp_used == status_one_pkg::BP_ZERO) begin
            nxt_cur.kind = status_one_pkg::OPK_WHOLE_ERASE; // failures here leave eerr alone
            nxt_cur.busy = 1'b1;
            nxt_cur.run = ST_RUN;
            nxt_cur.op_start = 1'b1;
          end
        end
      end
    end
    nxt_cur.active_bp = bp_used;
    nxt_cur.status_out = {nxt_cur.lock_copy, nxt_cur.perr, nxt_cur.eerr, nxt_cur.bp_vol,
                          nxt_cur.write_enable_latch, nxt_cur.busy};
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cur_ff <= '0;
      cur_ff.wp_sync <= 2'h3;
      cur_ff.run <= ST_IDLE;
      cur_ff.kind <= status_one_pkg::OPK_NONE;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign status_one_volatile = cur_ff.status_out;
  assign nv_write_data = cur_ff.nv_data;
  assign nv_write_strobe = cur_ff.nv_strobe;
  assign op_start = cur_ff.op_start;
  assign op_kind = cur_ff.kind;
  assign active_protect = cur_ff.active_bp;
  assign erase_suspend_req = cur_ff.ers_req;
  assign program_suspend_req = cur_ff.pgm_req;
endmodule
`default_nettype wire

// >>> core/spi_cmd_shifter.sv
// serial command receiver: samples link pins, assembles opcode, address and data
`timescale 1ns/1ns
`default_nettype none
module spi_cmd_shifter (
  input wire logic clock,
  input wire logic rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic frame_end,
  output logic [7:0] opcode,
  output logic [23:0] address,
  output logic [7:0] data,
  output logic data_valid,
  output logic [5:0] count
);
  typedef struct packed {
    logic [1:0] sck_sync;
    logic [1:0] cs_sync;
    logic [1:0] mosi_sync;
    logic sck_last;
    logic cs_last;
    logic [5:0] bits;
    logic [39:0] shift;
    logic frame_end;
  } shifter_t;
  shifter_t cur_ff, nxt_cur;
  logic rise;

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.sck_sync = {cur_ff.sck_sync[0], sck};
    nxt_cur.cs_sync = {cur_ff.cs_sync[0], cs_n};
    nxt_cur.mosi_sync = {cur_ff.mosi_sync[0], mosi};
    nxt_cur.sck_last = cur_ff.sck_sync[1];
    nxt_cur.cs_last = cur_ff.cs_sync[1];
    nxt_cur.frame_end = cur_ff.cs_sync[1] & ~cur_ff.cs_last;
    rise = cur_ff.sck_sync[1] & ~cur_ff.sck_last & ~cur_ff.cs_sync[1];
    // count restarts as a frame opens, so it still stands when the frame ends
    if (cur_ff.cs_last && !cur_ff.cs_sync[1]) begin
      nxt_cur.bits = '0;
    end else if (rise) begin
      nxt_cur.shift = {cur_ff.shift[38:0], cur_ff.mosi_sync[1]};
      if (cur_ff.bits != status_one_pkg::BIT_CNT_SATURATE) begin
        nxt_cur.bits = cur_ff.bits + status_one_pkg::BIT_CNT_ONE;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cur_ff <= '0;
      cur_ff.sck_sync <= 2'h0;
      cur_ff.cs_sync <= 2'h3;
      cur_ff.cs_last <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // opcode is the first byte; with 40 bits seen the fields are aligned
  always_comb begin
    if (cur_ff.bits >= status_one_pkg::BIT_CNT_FULL_FRAME) begin
      opcode = cur_ff.shift[39:32];
      address = cur_ff.shift[31:8];
    end else begin
      opcode = cur_ff.shift[7:0] >> 0;
      address = '0;
      if (cur_ff.bits >= status_one_pkg::BIT_CNT_FIRST_DATA) begin
        opcode = cur_ff.shift[15:8];
      end
      if (cur_ff.bits >= status_one_pkg::BIT_CNT_THIRD_BYTE) begin
        opcode = cur_ff.shift[23:16];
      end
      if (cur_ff.bits >= status_one_pkg::BIT_CNT_ADDR_END) begin
        opcode = cur_ff.shift[31:24];
        address = {cur_ff.shift[23:0]};
      end
    end
    data = cur_ff.shift[7:0];
    data_valid = (cur_ff.bits >= status_one_pkg::BIT_CNT_FIRST_DATA);
  end
  assign frame_end = cur_ff.frame_end;
  assign count = cur_ff.bits;
endmodule
`default_nettype wire

// >>> include/status_one_pkg.sv
// constants and types for the volatile status register one logic
package status_one_pkg;
  localparam int STATUS_W = 8;
  // bit positions of the volatile status register
  localparam int BIT_LOCK = 7;
  localparam int BIT_PERR = 6;
  localparam int BIT_EERR = 5;
  localparam int BIT_BP_HI = 4;
  localparam int BIT_BP_LO = 2;
  localparam int BIT_WEL = 1;
  localparam int BIT_BUSY = 0;
  localparam int BP_W = 3;
  // command opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_CLEAR_STATUS = 8'h30;
  localparam logic [7:0] OP_CLEAR_STATUS_ALT = 8'h82;
  localparam logic [7:0] OP_STATUS_CONFIG_WRITE = 8'h01;
  localparam logic [7:0] OP_ANY_REG_WRITE = 8'h71;
  localparam logic [7:0] OP_ANY_REG_READ = 8'h65;
  localparam logic [7:0] OP_READ_STATUS_ONE = 8'h05;
  localparam logic [7:0] OP_READ_STATUS_TWO = 8'h07;
  localparam logic [7:0] OP_ERASE_SUSPEND = 8'h75;
  localparam logic [7:0] OP_PROGRAM_SUSPEND = 8'h85;
  localparam logic [7:0] OP_SOFT_RESET = 8'hF0;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;
  localparam logic [7:0] OP_WHOLE_ARRAY_ERASE = 8'h60;
  // any-register addresses of status one and config one
  localparam logic [23:0] ADDR_STATUS_ONE_NV = 24'h00_0000;
  localparam logic [23:0] ADDR_CONFIG_ONE_NV = 24'h00_0002;
  localparam logic [23:0] ADDR_STATUS_ONE_V = 24'h80_0000;
  localparam logic [23:0] ADDR_CONFIG_ONE_V = 24'h80_0002;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [2:0] BP_ZERO = 3'h0;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam logic [5:0] BIT_CNT_ADDR_END = 6'h20;
  localparam logic [5:0] BIT_CNT_ONE = 6'h01;
  localparam logic [5:0] BIT_CNT_FIRST_DATA = 6'h10;
  localparam logic [5:0] BIT_CNT_THIRD_BYTE = 6'h18;
  localparam logic [5:0] BIT_CNT_FULL_FRAME = 6'h28;
  localparam logic [5:0] BIT_CNT_SATURATE = 6'h3F;

  typedef enum logic [2:0] {
    OPK_NONE, OPK_REG_WRITE, OPK_PROGRAM, OPK_ERASE, OPK_WHOLE_ERASE
  } op_kind_t;
endpackage

// >>> testbench/flash_status_checker_assertions.sv
// concurrent checks on the ports of the status register one logic
`timescale 1ns/1ns
`default_nettype none
module flash_status_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] status_one_nonvolatile,
  input wire logic protect_source_select,
  input wire logic op_done,
  input wire logic op_fail,
  input wire logic [7:0] status_one_volatile,
  input wire logic op_start,
  input wire logic [2:0] op_kind,
  input wire logic [2:0] active_protect,
  input wire logic erase_suspend_req,
  input wire logic program_suspend_req
);
  logic busy, write_enable_latch, errs;
  assign busy = status_one_volatile[status_one_pkg::BIT_BUSY];
  assign write_enable_latch = status_one_volatile[status_one_pkg::BIT_WEL];
  assign errs = status_one_volatile[status_one_pkg::BIT_PERR] | status_one_volatile[status_one_pkg::BIT_EERR];
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_start_needs_wel: assert property (op_start |-> busy && $past(write_enable_latch))
    else $error("operation started without latch");
  a_whole_erase_clear: assert property (op_start && op_kind == 3'h4 |-> active_protect == 3'h0)
    else $error("whole erase started while protected");
  a_done_frees: assert property (op_done && !op_fail && busy && !errs |=> !busy && !write_enable_latch)
    else $error("clean finish left busy or latch");
  a_fail_holds: assert property (op_done && op_fail && busy |=> busy && errs)
    else $error("failure not held busy with error");
  a_err_busy: assert property (errs |-> busy)
    else $error("error flag without busy");
  a_lock_follows: assert property ($changed(status_one_nonvolatile[7]) |-> ##[1:3] status_one_volatile[7] == status_one_nonvolatile[7])
    else $error("lock copy did not follow");
  a_reset_wel: assert property ($past(rst) |-> !write_enable_latch)
    else $error("latch set after reset");
  a_suspend_ok: assert property (erase_suspend_req || program_suspend_req |-> busy && !errs && !(erase_suspend_req && program_suspend_req))
    else $error("suspend outside running operation");
  a_busy_cause: assert property ($rose(busy) |-> op_start || errs)
    else $error("busy rose without cause");
  a_protect_source: assert property ((!protect_source_select && $stable(status_one_nonvolatile) && $stable(protect_source_select))[*3] |-> active_protect == status_one_nonvolatile[4:2])
    else $error("persistent protect bits not in force");
  c_whole: cover property (op_start && op_kind == 3'h4);
  c_fail: cover property (op_done && op_fail);
  c_susp: cover property (program_suspend_req);
endmodule
`default_nettype wire

// >>> testbench/spi_host_model.sv
// spi host model sending command frames in mode 0
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  input wire logic clock,
  output logic sck,
  output logic cs_n,
  output logic mosi
);
  localparam int HALF = 10;
  initial begin
    sck = 1'h0;
    cs_n = 1'h1;
    mosi = 1'h1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clock);
  endtask
  // n bits msb first, left aligned in v
  task automatic send(input logic [39:0] v, input int n);
    wait_clk(1);
    cs_n = 1'h0;
    for (int i = 0; i < n; i++) begin
      mosi = v[39-i];
      wait_clk(HALF);
      sck = 1'h1;
      wait_clk(HALF);
      sck = 1'h0;
    end
    wait_clk(HALF);
    cs_n = 1'h1;
    // released line shows no stale value
    mosi = ~mosi;
    wait_clk(12);
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the status register one logic
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clock, rst, sck, cs_n, mosi, write_protect_n, soft_reset, protect_source_select;
  logic region_protected, otp_locked_target, op_done, op_fail, nv_write_strobe, op_start;
  logic erase_suspend_req, program_suspend_req;
  logic [7:0] status_one_nonvolatile, status_one_volatile, nv_write_data, d;
  logic [2:0] op_kind, active_protect;
  logic [2:0] q_op[$], q_nv[$], q_sus[$];
  int n_fail = 0, comparisons = 0, cycles = 0, seed = 73;
  spi_host_model host_u (.clock(clock), .sck(sck), .cs_n(cs_n), .mosi(mosi));
  flash_status_reg_one_logic dut_u (.clock(clock), .rst(rst), .sck(sck), .cs_n(cs_n), .mosi(mosi),
    .write_protect_n(write_protect_n), .soft_reset(soft_reset), .status_one_nonvolatile(status_one_nonvolatile),
    .protect_source_select(protect_source_select), .region_protected(region_protected),
    .otp_locked_target(otp_locked_target), .op_done(op_done), .op_fail(op_fail),
    .status_one_volatile(status_one_volatile), .nv_write_data(nv_write_data), .nv_write_strobe(nv_write_strobe),
    .op_start(op_start), .op_kind(op_kind), .active_protect(active_protect),
    .erase_suspend_req(erase_suspend_req), .program_suspend_req(program_suspend_req));
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic check_ev(input logic [2:0] got, ref logic [2:0] q[$]);
    logic [2:0] e;
    e = (q.size() != 0) ? q.pop_front() : 3'hx;
    comparisons++;
    if (got !== e) begin
      n_fail++;
      $display("BAD %0t event %h want %h", $time, got, e);
    end
  endtask
  task automatic st(input logic [7:0] m, input logic [7:0] e);
    check(status_one_volatile & m, e);
  endtask
  task automatic c(input logic [7:0] op, input int n);
    host_u.send({op, 32'h0}, n);
  endtask
  task automatic wr(input logic [7:0] v);
    c(status_one_pkg::OP_WRITE_ENABLE, 8);
    host_u.send({status_one_pkg::OP_STATUS_CONFIG_WRITE, v, 24'h0}, 16);
  endtask
  task automatic fin(input logic f);
    @(negedge clock);
    op_done = 1'h1;
    op_fail = f;
    @(negedge clock);
    op_done = 1'h0;
    op_fail = 1'h0;
    host_u.wait_clk(3);
  endtask
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      print_verdict();
    end
    if (op_start) check_ev(op_kind, q_op);
    if (nv_write_strobe) check_ev(nv_write_data[4:2], q_nv);
    if (nv_write_strobe) status_one_nonvolatile <= nv_write_data;
    if (erase_suspend_req || program_suspend_req) check_ev({1'h0, erase_suspend_req, program_suspend_req}, q_sus);
  end
  initial begin
    {rst, write_protect_n, soft_reset, protect_source_select} = 4'hC;
    {region_protected, otp_locked_target, op_done, op_fail} = 4'h0;
    status_one_nonvolatile = 8'h00;
    repeat (6) @(negedge clock);
    rst = 1'h0;
    host_u.wait_clk(4);
    st(8'hFF, 8'h00);
    status_one_nonvolatile = 8'h80;
    host_u.wait_clk(4);
    st(8'h80, 8'h80);
    status_one_nonvolatile = 8'h00;
    c(status_one_pkg::OP_PAGE_PROGRAM, 40);
    st(8'h03, 8'h00);
    c(status_one_pkg::OP_WRITE_ENABLE, 8);
    st(8'h03, 8'h02);
    c(status_one_pkg::OP_WRITE_DISABLE, 8);
    st(8'h03, 8'h00);
    $display("test latch done");
    for (int i = 0; i < 2; i++) begin
      c(status_one_pkg::OP_WRITE_ENABLE, 8);
      q_op.push_back(i ? 3'h3 : 3'h2);
      c(i ? status_one_pkg::OP_SECTOR_ERASE : status_one_pkg::OP_PAGE_PROGRAM, 40);
      st(8'h03, 8'h03);
      c(status_one_pkg::OP_WRITE_DISABLE, 8);
      st(8'h02, 8'h02);
      c(i ? status_one_pkg::OP_PROGRAM_SUSPEND : status_one_pkg::OP_ERASE_SUSPEND, 8);
      q_sus.push_back(i ? 3'h2 : 3'h1);
      c(i ? status_one_pkg::OP_ERASE_SUSPEND : status_one_pkg::OP_PROGRAM_SUSPEND, 8);
      fin(1'h0);
      st(8'h03, 8'h00);
      c(status_one_pkg::OP_WRITE_ENABLE, 8);
      q_op.push_back(i ? 3'h3 : 3'h2);
      c(i ? status_one_pkg::OP_SECTOR_ERASE : status_one_pkg::OP_PAGE_PROGRAM, 40);
      fin(1'h1);
      st(8'h61, i ? 8'h21 : 8'h41);
      c(status_one_pkg::OP_PAGE_PROGRAM, 40);
      c(i ? status_one_pkg::OP_CLEAR_STATUS : status_one_pkg::OP_CLEAR_STATUS_ALT, 8);
      st(8'h61, 8'h00);
      c(status_one_pkg::OP_WRITE_DISABLE, 8);
      st(8'h02, 8'h00);
    end
    $display("test operations done");
    d = 8'($random(seed)) & 8'h1C;
    q_op.push_back(3'h1);
    q_nv.push_back(d[4:2]);
    wr(d);
    fin(1'h0);
    st(8'h7F, d);
    protect_source_select = 1'h1;
    d = 8'($random(seed)) | 8'h64;
    wr(d);
    st(8'hFF, {3'h0, d[4:2], 2'h2});
    check({5'h0, active_protect}, {5'h0, d[4:2]});
    c(status_one_pkg::OP_WHOLE_ARRAY_ERASE, 8);
    st(8'h21, 8'h00);
    region_protected = 1'h1;
    otp_locked_target = 1'($random(seed));
    c(status_one_pkg::OP_SECTOR_ERASE, 40);
    st(8'h21, 8'h21);
    c(status_one_pkg::OP_CLEAR_STATUS, 8);
    otp_locked_target = 1'h1;
    c(status_one_pkg::OP_PAGE_PROGRAM, 40);
    st(8'h41, 8'h41);
    c(status_one_pkg::OP_CLEAR_STATUS, 8);
    otp_locked_target = 1'h0;
    wr(8'h00);
    c(status_one_pkg::OP_WRITE_ENABLE, 8);
    q_op.push_back(3'h4);
    region_protected = 1'($random(seed));
    c(status_one_pkg::OP_WHOLE_ARRAY_ERASE, 8);
    fin(1'h0);
    st(8'h21, 8'h00);
    region_protected = 1'h0;
    $display("test protection done");
    status_one_nonvolatile[7] = 1'h1;
    write_protect_n = 1'($random(seed));
    wr(8'h1C);
    st(8'h9C, write_protect_n ? 8'h9C : 8'h80);
    write_protect_n = 1'h1;
    c(status_one_pkg::OP_WRITE_ENABLE, 8);
    host_u.send({status_one_pkg::OP_ANY_REG_WRITE, status_one_pkg::ADDR_STATUS_ONE_V, 8'h08}, 40);
    st(8'h1F, 8'h0A);
    soft_reset = 1'h1;
    host_u.wait_clk(6);
    soft_reset = 1'h0;
    host_u.wait_clk(6);
    st(8'h03, 8'h00);
    check(8'(q_op.size() + q_nv.size() + q_sus.size()), 8'h00);
    $display("test lock and reset done");
    print_verdict();
  end
endmodule
bind flash_status_reg_one_logic flash_status_checker chk_u (
  .clock(clock),
  .rst(rst),
  .status_one_nonvolatile(status_one_nonvolatile),
  .protect_source_select(protect_source_select),
  .op_done(op_done),
  .op_fail(op_fail),
  .status_one_volatile(status_one_volatile),
  .op_start(op_start),
  .op_kind(op_kind),
  .active_protect(active_protect),
  .erase_suspend_req(erase_suspend_req),
  .program_suspend_req(program_suspend_req)
);
`default_nettype wire
